// *** logic/quad_phase_fetch_execute_core.sv ***
// four-phase fetch/execute sequencer with flushing branch and harvard buses
// Notes on behaviour
// (RULE1) osc_in divided into four phases per cycle
// (RULE2) program counter increments in phase_one
// (RULE3) fetched word latched at fetch phase_four
// (RULE4) instruction executes phase_two through phase_four next cycle
// (RULE5) data read phase_two, data write phase_four
// (RULE6) fetch overlaps execute, one instruction per cycle
// (RULE7) branch flushes fetched word, takes two cycles
// (RULE8) rc mode drives cycle clock at quarter rate
// (RULE9) master_clear_n low resets the device
// (RULE10) program and data memory on separate buses
// (RULE11) data eeprom reached only through pointer 0h-3Fh
// (RULE12) reset vector 0000h, interrupt vector 0004h
// (RULE13) reset holds sequencer; restarts phase_one, empty pipeline
`timescale 1ns/10ps
`default_nettype none
module quad_phase_fetch_execute_core #(
  parameter int PC_BITS = qpc_pkg::PC_W,
  parameter int EE_DEPTH = 64
) (
  // clock (osc_in) and master clear
  input wire logic mclk,
  input wire logic nrst,
  input wire logic master_clear_n,
  // oscillator mode and cycle clock
  input wire logic rc_mode,
  output logic cycle_clock_out,
  output logic cycle_clock_oe,
  // phase outputs
  output qpc_pkg::phase_s phase,
  // program memory bus
  output logic [qpc_pkg::PC_W-1:0] pmem_addr,
  output logic pmem_rd,
  input wire logic [qpc_pkg::INSN_W-1:0] pmem_data,
  // execute side
  output logic [qpc_pkg::INSN_W-1:0] insn,
  output logic insn_valid,
  output logic [qpc_pkg::PC_W-1:0] insn_pc,
  input wire qpc_pkg::redirect_s redirect,
  input wire logic irq,
  // data memory bus
  input wire qpc_pkg::dmem_s dmem_req,
  output logic dmem_rd,
  output logic dmem_wr,
  output logic [qpc_pkg::DADDR_W-1:0] dmem_addr,
  output logic [qpc_pkg::DATA_W-1:0] dmem_wdata,
  // data eeprom pointer access
  input wire logic ee_ptr_we,
  input wire logic [qpc_pkg::EE_ADDR_W-1:0] ee_ptr_in,
  input wire logic ee_wr,
  input wire logic [qpc_pkg::DATA_W-1:0] ee_wdata,
  output logic [qpc_pkg::EE_ADDR_W-1:0] ee_ptr,
  output logic [qpc_pkg::DATA_W-1:0] ee_rdata
);
  initial begin
    if (PC_BITS != qpc_pkg::PC_W) $error("PC_BITS must match package width");
    if (EE_DEPTH != 64) $error("EE_DEPTH must be 64");
  end

  typedef enum logic [1:0] {ST_ONE, ST_TWO, ST_THREE, ST_FOUR} qstate_e;

  // master clear pin passes three flops; counts when second and third agree
  logic [2:0] master_clear_n_sync_r;
  logic run_r;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      master_clear_n_sync_r <= 3'h0;
    end else begin
      master_clear_n_sync_r <= {master_clear_n_sync_r[1:0], master_clear_n};
    end
  end
  // run state after this edge; the cycle clock needs it one edge early
  wire run_nxt = (master_clear_n_sync_r[1] == master_clear_n_sync_r[2]) ? master_clear_n_sync_r[2] : run_r;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      run_r <= 1'b0;
    end else begin
      run_r <= run_nxt; // [RULE9]
    end
  end

  // phase sequencer
  qstate_e q_r, q_nxt;
  always_comb begin
    unique case (q_r)
      ST_ONE: q_nxt = ST_TWO;
      ST_TWO: q_nxt = ST_THREE;
      ST_THREE: q_nxt = ST_FOUR;
      ST_FOUR: q_nxt = ST_ONE;
    endcase
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      q_r <= ST_ONE;
    end else if (!run_r) begin
      q_r <= ST_ONE; // [RULE13]
    end else begin
      q_r <= q_nxt; // [RULE1]
    end
  end

  wire ph1 = run_r && (q_r == ST_ONE);
  wire ph2 = run_r && (q_r == ST_TWO);
  wire ph3 = run_r && (q_r == ST_THREE);
  wire ph4 = run_r && (q_r == ST_FOUR);
  assign phase = '{one: ph1, two: ph2, three: ph3, four: ph4};

  // cycle clock: high in phase_one and phase_two, quarter rate [RULE8]
  // a held sequencer restarts in phase_one, so the first cycle is high too
  logic clkout_r;
  wire clkout_nxt = run_nxt && (!run_r || q_r == ST_FOUR || q_r == ST_ONE);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clkout_r <= 1'b0;
    end else begin
      clkout_r <= clkout_nxt;
    end
  end
  assign cycle_clock_out = clkout_r;
  assign cycle_clock_oe = rc_mode; // [RULE8]

  // fetch/execute pipeline
  logic [12:0] pc_r;
  logic [12:0] fpc_r;
  logic [13:0] ir_r;
  logic ir_full_r;
  logic [13:0] ex_r;
  logic [12:0] ex_pc_r;
  logic ex_valid_r;
  logic irq_pend_r;

  wire take_redirect = ph4 && ex_valid_r && redirect.valid;
  wire take_irq = ph4 && irq_pend_r && !take_redirect;
  wire [12:0] new_pc = take_redirect ? redirect.target : qpc_pkg::IRQ_VECTOR;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_pend_r <= 1'b0;
    end else if (!run_r) begin
      irq_pend_r <= 1'b0;
    end else if (irq) begin
      irq_pend_r <= 1'b1; // set wins over clear
    end else if (take_irq) begin
      irq_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pc_r <= qpc_pkg::RESET_VECTOR;
      fpc_r <= qpc_pkg::RESET_VECTOR;
    end else if (!run_r) begin
      pc_r <= qpc_pkg::RESET_VECTOR; // [RULE12] [RULE13]
      fpc_r <= qpc_pkg::RESET_VECTOR;
    end else if (take_redirect || take_irq) begin
      pc_r <= new_pc; // [RULE7] [RULE12]
    end else if (ph1) begin
      fpc_r <= pc_r;
      pc_r <= pc_r + 13'h0001; // [RULE2]
    end
  end

  assign pmem_addr = fpc_r; // [RULE10]
  assign pmem_rd = ph4;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ir_r <= 14'h0000;
      ir_full_r <= 1'b0;
    end else if (!run_r) begin
      ir_full_r <= 1'b0; // [RULE13]
    end else if (ph4) begin
      ir_r <= pmem_data; // [RULE3]
      ir_full_r <= !(take_redirect || take_irq); // [RULE7]
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ex_r <= 14'h0000;
      ex_pc_r <= 13'h0000;
      ex_valid_r <= 1'b0;
    end else if (!run_r) begin
      ex_valid_r <= 1'b0;
    end else if (ph1) begin
      ex_r <= ir_r; // [RULE4] [RULE6]
      ex_pc_r <= fpc_r;
      ex_valid_r <= ir_full_r;
    end
  end
  assign insn = ex_r;
  assign insn_pc = ex_pc_r;
  assign insn_valid = ex_valid_r && !ph1; // [RULE4]

  // data bus strobes fixed to phases of the execute cycle
  assign dmem_rd = ph2 && ex_valid_r && dmem_req.rd; // [RULE5] [RULE10]
  assign dmem_wr = ph4 && ex_valid_r && dmem_req.wr; // [RULE5]
  assign dmem_addr = dmem_req.addr;
  assign dmem_wdata = dmem_req.wdata;

  ee_window #(
    .DEPTH(EE_DEPTH),
    .AW(qpc_pkg::EE_ADDR_W),
    .DW(qpc_pkg::DATA_W)
  ) u_ee (
    .mclk(mclk),
    .nrst(nrst),
    .ptr_we(ee_ptr_we),
    .ptr_in(ee_ptr_in),
    .wr(ee_wr), // [RULE11]
    .wdata(ee_wdata),
    .ptr(ee_ptr),
    .rdata(ee_rdata)
  );

  // assertions
  property p_phase_order;
    @(posedge mclk) disable iff (!nrst)
      ph1 && run_r ##1 run_r |-> ph2;
  endproperty
  a_phase_order: assert property (p_phase_order) else $error("phase two must follow one"); // [RULE1]

  property p_pc_inc;
    @(posedge mclk) disable iff (!nrst)
      ph1 |=> pc_r == $past(pc_r) + 13'h0001;
  endproperty
  a_pc_inc: assert property (p_pc_inc) else $error("pc not incremented in phase one"); // [RULE2]

  property p_ir_latch;
    @(posedge mclk) disable iff (!nrst)
      ph4 |=> ir_r == $past(pmem_data);
  endproperty
  a_ir_latch: assert property (p_ir_latch) else $error("instruction not latched"); // [RULE3]

  sequence s_fetched;
    ph4 && !take_redirect && !take_irq;
  endsequence
  property p_exec_next;
    @(posedge mclk) disable iff (!nrst)
      s_fetched ##1 run_r |=> ex_valid_r && ex_r == $past(ir_r);
  endproperty
  a_exec_next: assert property (p_exec_next) else $error("fetched word not executed"); // [RULE4]

  property p_dmem_phase;
    @(posedge mclk) disable iff (!nrst)
      (dmem_rd |-> q_r == ST_TWO) and (dmem_wr |-> q_r == ST_FOUR);
  endproperty
  a_dmem_phase: assert property (p_dmem_phase) else $error("data strobe in wrong phase"); // [RULE5]

  property p_flush;
    @(posedge mclk) disable iff (!nrst)
      take_redirect ##1 run_r [*4] |=> !ex_valid_r;
  endproperty
  a_flush: assert property (p_flush) else $error("branch did not flush"); // [RULE7]

  property p_clkout;
    @(posedge mclk) disable iff (!nrst)
      (ph1 |-> clkout_r) and (ph2 |-> clkout_r ##1 !clkout_r);
  endproperty
  a_clkout: assert property (p_clkout) else $error("cycle clock shape wrong"); // [RULE8]

  property p_reset_hold;
    @(posedge mclk) disable iff (!nrst)
      !run_r |=> q_r == ST_ONE && pc_r == qpc_pkg::RESET_VECTOR && !ex_valid_r;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("not held in reset"); // [RULE13]

  property p_irq_vec;
    @(posedge mclk) disable iff (!nrst)
      take_irq |=> pc_r == qpc_pkg::IRQ_VECTOR;
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("interrupt vector wrong"); // [RULE12]
endmodule : quad_phase_fetch_execute_core
`default_nettype wire

// *** logic/qpc_pkg.sv ***
// package: constants and carriers for the four-phase fetch/execute sequencer
package qpc_pkg;
  localparam int PC_W = 13;
  localparam int INSN_W = 14;
  localparam int DADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int EE_ADDR_W = 6;
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [5:0] EE_LAST = 6'h3F;
  localparam int PHASES = 4;
  localparam int SEL_N = 8;
  localparam int SEL_W = 3;
  localparam logic [1:0] PH_ONE = 2'h0;
  localparam logic [1:0] PH_TWO = 2'h1;
  localparam logic [1:0] PH_THREE = 2'h2;
  localparam logic [1:0] PH_FOUR = 2'h3;

  typedef struct packed {
    logic one;
    logic two;
    logic three;
    logic four;
  } phase_s;

  // execute-side redirect request, sampled at phase_four of the execute cycle
  typedef struct packed {
    logic valid;
    logic [12:0] target;
  } redirect_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } dmem_s;
endpackage : qpc_pkg

// *** logic/ee_window.sv ***
// data eeprom reached only through an address pointer, a small memory
`timescale 1ns/10ps
`default_nettype none
module ee_window #(
  parameter int DEPTH = 64,
  parameter int AW = 6,
  parameter int DW = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // pointer and access
  input wire logic ptr_we,
  input wire logic [AW-1:0] ptr_in,
  input wire logic wr,
  input wire logic [DW-1:0] wdata,
  output logic [AW-1:0] ptr,
  output logic [DW-1:0] rdata
);
  initial begin
    if (DEPTH != (1 << AW)) $error("ee_window depth must equal 2**AW");
  end
  logic [DW-1:0] mem [DEPTH];
  logic [AW-1:0] ptr_r;
  logic [DW-1:0] rdata_r;
  assign ptr = ptr_r;
  assign rdata = rdata_r;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ptr_r <= '0;
    end else if (ptr_we) begin
      ptr_r <= ptr_in;
    end
  end
  // addressed only via pointer, never by the data bus address [RULE11]
  always_ff @(posedge mclk) begin
    if (wr) begin
      mem[ptr_r] <= wdata;
    end
    rdata_r <= mem[ptr_r];
  end
endmodule : ee_window
`default_nettype wire

// *** test/tb.sv ***
// self-checking bench for the four-phase fetch/execute core
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic mclk = 0, nrst = 0, master_clear_n = 0, rc_mode = 1, rc_nxt = 1, irq = 0;
  logic ee_ptr_we = 0, ee_wr = 0;
  logic [5:0] ee_ptr_in = 6'h00;
  logic [7:0] ee_wdata = 8'h00;
  qpc_pkg::redirect_s redirect = '0;
  qpc_pkg::dmem_s dmem_req = {1'b1, 1'b1, 7'h5A, 8'hC3};
  wire logic cko, ckoe, prd, iv, drd, dwr;
  wire qpc_pkg::phase_s phase;
  wire logic [12:0] paddr, ipc;
  wire logic [13:0] insn, pd;
  wire logic [6:0] daddr;
  wire logic [7:0] dwd, erd;
  wire logic [5:0] eptr;
  int err_count = 0, compares = 0;
  logic v;
  logic [12:0] pc, fa;
  // program memory image: each word encodes the low seven address bits, so words repeat every 128 addresses
  function automatic logic [13:0] mem(input logic [12:0] a);
    return {a[6:0], ~a[6:0]};
  endfunction : mem
  assign pd = mem(paddr);
  always #10 mclk = ~mclk;
  quad_phase_fetch_execute_core DUT (.mclk(mclk), .nrst(nrst), .master_clear_n(master_clear_n),
    .rc_mode(rc_mode), .cycle_clock_out(cko), .cycle_clock_oe(ckoe), .phase(phase),
    .pmem_addr(paddr), .pmem_rd(prd), .pmem_data(pd), .insn(insn), .insn_valid(iv),
    .insn_pc(ipc), .redirect(redirect), .irq(irq), .dmem_req(dmem_req), .dmem_rd(drd),
    .dmem_wr(dwr), .dmem_addr(daddr), .dmem_wdata(dwd), .ee_ptr_we(ee_ptr_we),
    .ee_ptr_in(ee_ptr_in), .ee_wr(ee_wr), .ee_wdata(ee_wdata), .ee_ptr(eptr), .ee_rdata(erd));
  task chk(input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask : chk
  task wait_ph1;
    int n;
    n = 0;
    while (phase.one !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    chk(1, phase.one);
  endtask : wait_ph1
  // one instruction cycle, starting and ending at the falling edge inside phase_one
  task cyc(input logic br, input logic [12:0] tgt, input logic ir);
    for (int q = 0; q < 4; q++) begin
      chk(4'b1000 >> q, phase);
      chk(rc_mode, ckoe);
      if (rc_mode) chk(q < 2, cko);
      chk(q == 3, prd);
      chk(q == 1 && iv, drd);
      chk(q == 3 && iv, dwr);
      if (q == 1) v = iv;
      if (q == 1 && iv) pc = ipc;
      if (q == 1 && iv) chk(mem(ipc), insn);
      if (q == 3) fa = paddr;
      @(posedge mclk);
      #2;
      if (q == 0) irq = ir;
      if (q == 0) rc_mode = rc_nxt;
      if (q == 1) redirect = {br, tgt};
      if (q == 3) redirect = '0;
      @(negedge mclk);
    end
  endtask : cyc
  task t_pipe;
    logic seen;
    logic [12:0] f0, p0;
    seen = 0;
    wait_ph1;
    for (int c = 0; c < 8; c++) begin
      cyc(0, 13'h0000, 0);
      if (c == 0) chk(13'h0000, fa);
      else chk(f0 + 13'h0001, fa);
      if (seen) chk(1, v);
      if (seen) chk(p0 + 13'h0001, pc);
      if (!seen && v) chk(13'h0000, pc);
      if (v) seen = 1;
      p0 = pc;
      f0 = fa;
    end
    chk(1, seen);
    chk(7'h5A, daddr);
    chk(8'hC3, dwd);
    $display("pipeline test done");
  endtask : t_pipe
  task t_branch;
    rc_nxt = 0;
    cyc(1, 13'h0100, 0);
    cyc(0, 13'h0000, 0);
    chk(0, v);
    chk(13'h0100, fa);
    cyc(0, 13'h0000, 0);
    chk(1, v);
    chk(13'h0100, pc);
    $display("branch test done");
  endtask : t_branch
  task t_irq;
    logic hit;
    hit = 0;
    rc_nxt = 1;
    cyc(0, 13'h0000, 1);
    for (int c = 0; c < 4; c++) begin
      cyc(0, 13'h0000, 0);
      if (fa === 13'h0004) hit = 1;
    end
    chk(1, hit);
    $display("interrupt test done");
  endtask : t_irq
  task t_master_clear_n;
    @(posedge mclk);
    #2;
    master_clear_n = 0;
    repeat (8) @(negedge mclk);
    chk(4'h0, phase);
    chk(0, iv);
    @(posedge mclk);
    #2;
    master_clear_n = 1;
    @(negedge mclk);
    wait_ph1;
    cyc(0, 13'h0000, 0);
    chk(13'h0000, fa);
    chk(0, v);
    $display("master clear test done");
  endtask : t_master_clear_n
  task ee(input logic pw, input logic [5:0] p, input logic w, input logic [7:0] d);
    @(posedge mclk);
    #2;
    ee_ptr_we = pw;
    ee_ptr_in = p;
    ee_wr = w;
    ee_wdata = d;
  endtask : ee
  task t_ee;
    ee(1, 6'h3F, 0, 8'h00);
    ee(0, 6'h00, 1, 8'hA5);
    ee(1, 6'h00, 0, 8'h00);
    ee(0, 6'h00, 1, 8'h5A);
    ee(0, 6'h00, 0, 8'h00);
    ee(0, 6'h00, 0, 8'h00);
    chk(6'h00, eptr);
    chk(8'h5A, erd);
    ee(1, 6'h3F, 0, 8'h00);
    ee(0, 6'h00, 0, 8'h00);
    ee(0, 6'h00, 0, 8'h00);
    chk(6'h3F, eptr);
    chk(8'hA5, erd);
    $display("eeprom pointer test done");
  endtask : t_ee
  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (3) @(posedge mclk);
    #2;
    nrst = 1;
    master_clear_n = 1;
    t_pipe;
    t_branch;
    t_irq;
    t_master_clear_n;
    t_ee;
    report_and_stop;
  end
  // the tests need well under 200 cycles
  initial begin
    #100000;
    err_count++;
    report_and_stop;
  end
endmodule : tb
`default_nettype wire
